// ==== pkg/nic_pkg.sv ====
// Constants for the nested interrupt controller
package nic_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_PRIO0   = 6'h00;
   localparam logic [5:0] OFS_PRIO1   = 6'h04;
   localparam logic [5:0] OFS_PRIO2   = 6'h08;
   localparam logic [5:0] OFS_PRIO3   = 6'h0C;
   localparam logic [5:0] OFS_EXTCFG  = 6'h10;
   localparam logic [5:0] OFS_EXTSEL  = 6'h14;
   localparam logic [5:0] OFS_PEN     = 6'h18;
   localparam logic [5:0] OFS_PEND    = 6'h1C;
   localparam logic [5:0] OFS_LEVEL   = 6'h20;
   // Reset values
   localparam logic [7:0] PRIO_RST    = 8'hFF;
   localparam logic [3:0] PRIO3_RO    = 4'hF;
   // Level codes held in I1:I0
   localparam logic [1:0] LVL0        = 2'h2;
   localparam logic [1:0] LVL1        = 2'h1;
   localparam logic [1:0] LVL2        = 2'h0;
   localparam logic [1:0] LVL3        = 2'h3;
   // Level bit positions in the condition code register
   localparam int         CC_I1_BIT   = 5;
   localparam int         CC_I0_BIT   = 3;
   // Vector table
   localparam int         NVEC        = 14;
   localparam logic [15:0] VEC_RST    = 16'hFFFE;
   localparam logic [15:0] VEC_TRAP   = 16'hFFFC;
   localparam logic [15:0] VEC_TOP    = 16'hFFFA;
   // Vectors able to leave halt
   localparam logic [13:0] HALT_WAKE  = 14'h20FF;
   // Vectors fed by external pin groups
   localparam logic [13:0] EXT_VEC    = 14'h003C;
   localparam int         EXT_FIRST   = 2;
   // Edge modes
   localparam logic [1:0] EDGE_FALL   = 2'h0;
   localparam logic [1:0] EDGE_RISE   = 2'h1;
   localparam logic [1:0] EDGE_BOTH   = 2'h2;
   localparam logic [1:0] EDGE_FLOW   = 2'h3;
   // Last stack sequence step and AXI answers
   localparam logic [2:0] STK_LAST    = 3'h4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/nic_top.sv ====
// Nested interrupt controller with AXI4-Lite registers
//
// What this block does
// - After the instruction ends, push PC, X, A and CC before entry.
// - On entry, load the level bits from the vector's stored priority.
// - Load PC from fixed top-of-memory vector slot ordered by hardware priority.
// - Return pops all registers, level bits included, resuming the old level.
// - Current level lives in condition code bits five and three.
// - Four levels coded 10, 01, 00, 11; level three disables.
// - Highest software priority wins; lower vector index breaks ties.
// - Unserviced requests stay latched until they become highest.
// - Top pin, trap and reset rank above all and beat level three.
// - Non-maskable sources ignore level, stack except reset, set level three.
// - Non-maskable sources wake the core from halt.
// - Trap taken when executed; its handler stays open to the top pin.
// - Reset ranks first; its routine runs at level three.
// - Maskable requests need enable and priority above current level.
// - Top pin raises on a chosen edge and is handled like a trap.
// - Edge external requests latch and clear on handler entry.
// - Selected pins of one group are ORed onto one line.
// - Peripheral request latched while flag and enable are both set.
// - A clear sequence drops the latched request, even if pending.
// - Any request ends wait; only wake-capable ones end halt.
// - After halt, wake-capable winner first; others follow.
// - Level instructions from the core also write the level bits.
// - Priority writes coding level zero are ignored per bit pair.
`timescale 1ns/100ps
module nic_top
   import nic_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt sources
   input  wire logic        top_level_pin_irq,
   input  wire logic [15:0] ext_pin,
   input  wire logic [13:0] periph_flag,
   input  wire logic [13:0] periph_clr,
   // Core side
   input  wire logic        instr_end,
   input  wire logic        trap_instr,
   input  wire logic        interrupt_return_instr_instr,
   input  wire logic        lvl_wr,
   input  wire logic [1:0]  lvl_wdata,
   input  wire logic        halt_mode,
   input  wire logic        wait_mode,
   input  wire logic [7:0]  pop_data,
   output logic             busy,
   output logic             stack_push,
   output logic             stack_pop,
   output logic [2:0]       stack_sel,
   output logic             fetch,
   output logic [15:0]      vector_addr,
   output logic [7:0]       condition_code_reg,
   output logic             wake
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef enum logic [2:0] {S_IDLE, S_PUSH, S_FETCH, S_POP} nic_st_e;

   typedef struct packed {
      logic        aw_v;
      logic [5:0]  awaddr;
      logic        w_v;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] prio;
      logic [9:0]  ext_cfg;
      logic [15:0] ext_sel;
      logic [13:0] pen;
      logic [13:0] pend;
      logic        tli_pend;
      logic        tli_q;
      logic [3:0]  grp_q;
      logic [1:0]  lvl;
      logic [1:0]  new_lvl;
      nic_st_e     st;
      logic [2:0]  cnt;
      logic [15:0] vec;
      logic        halt_exit;
   } nic_s;

   nic_s s_q;
   nic_s s_d;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [1:0] rank(input logic [1:0] l);
      case (l)
         LVL0:    rank = 2'h0;
         LVL1:    rank = 2'h1;
         LVL2:    rank = 2'h2;
         default: rank = 2'h3;
      endcase
   endfunction

   function automatic logic edge_hit(input logic [1:0] m,
                                     input logic       p,
                                     input logic       n);
      case (m)
         EDGE_FALL: edge_hit = p & ~n;
         EDGE_RISE: edge_hit = ~p & n;
         EDGE_BOTH: edge_hit = p ^ n;
         default:   edge_hit = (p & ~n) | ~n;
      endcase
   endfunction

   function automatic logic [7:0] prio_wr(input logic [7:0] old,
                                          input logic [7:0] d);
      logic [7:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (d[2*i+:2] != LVL0) begin
            r[2*i+:2] = d[2*i+:2];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Source lines and pending latches

   logic [3:0]  grp;
   logic [13:0] src;
   logic [13:0] pend_d;
   logic [13:0] clr_ent;
   logic        tli_ev;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_grp
         assign grp[g] = |(ext_pin[4*g+:4] & s_q.ext_sel[4*g+:4]);
      end
      for (g = 0; g < NVEC; g++) begin : g_vec
         if (EXT_VEC[g]) begin : g_ext
            assign src[g] = edge_hit(s_q.ext_cfg[2*(g-EXT_FIRST)+2+:2],
                                     s_q.grp_q[g-EXT_FIRST],
                                     grp[g-EXT_FIRST]);
         end else begin : g_per
            assign src[g] = periph_flag[g] & s_q.pen[g];
         end
         // Set wins over clear; unserviced requests stay latched
         assign pend_d[g] = src[g] |
                            (s_q.pend[g] & ~periph_clr[g] & ~clr_ent[g]);
      end
   endgenerate

   assign tli_ev = edge_hit(s_q.ext_cfg[1:0], s_q.tli_q, top_level_pin_irq);

   ////////////////////////////////////////////////////////////////////////
   // Arbitration

   logic [13:0] cand;
   logic        win_v;
   logic [3:0]  win_i;
   logic [1:0]  win_r;
   logic        tli_ok;

   always_comb begin
      logic [1:0] r;
      r = 2'h0;
      win_v = 1'b0;
      win_i = 4'h0;
      win_r = 2'h0;
      // Halt exit limits the first winner
      cand = s_q.pend & ~(s_q.halt_exit ? ~HALT_WAKE : 14'h0000);
      cand[0] = 1'b0;
      for (int v = NVEC - 1; v > 0; v--) begin
         r = rank(s_q.prio[2*v+:2]);
         if (cand[v] && r > rank(s_q.lvl) && (!win_v || r >= win_r)) begin
            win_v = 1'b1;
            win_i = 4'(v);
            win_r = r;
         end
      end
      tli_ok = s_q.tli_pend;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   logic wr_go;
   logic rd_hit;
   logic [7:0] prio3_new;

   assign prio3_new = prio_wr({PRIO3_RO, s_q.prio[27:24]}, s_q.wdata[7:0]);

   // Return takes precedence over entry, so no external request is cleared then
   assign clr_ent = (s_q.st == S_IDLE && instr_end && !interrupt_return_instr_instr && !trap_instr && !tli_ok && win_v) ?
                    (EXT_VEC & 14'(14'h1 << win_i)) : 14'h0000;

   always_comb begin
      s_d = s_q;
      rd_hit = 1'b1;
      wr_go = s_q.aw_v & s_q.w_v & ~s_q.bvalid;

      // AXI write capture in either order
      if (s_axi_awvalid && !s_q.aw_v) begin
         s_d.aw_v = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.w_v) begin
         s_d.w_v = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_d.aw_v = 1'b0;
         s_d.w_v = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         case (s_q.awaddr)
            OFS_PRIO0: if (s_q.wstrb[0]) s_d.prio[7:0] = prio_wr(s_q.prio[7:0], s_q.wdata[7:0]);
            OFS_PRIO1: if (s_q.wstrb[0]) s_d.prio[15:8] = prio_wr(s_q.prio[15:8], s_q.wdata[7:0]);
            OFS_PRIO2: if (s_q.wstrb[0]) s_d.prio[23:16] = prio_wr(s_q.prio[23:16], s_q.wdata[7:0]);
            OFS_PRIO3: if (s_q.wstrb[0]) s_d.prio[27:24] = prio3_new[3:0];
            OFS_EXTCFG: begin
               if (s_q.wstrb[0]) s_d.ext_cfg[7:0] = s_q.wdata[7:0];
               if (s_q.wstrb[1]) s_d.ext_cfg[9:8] = s_q.wdata[9:8];
            end
            OFS_EXTSEL: begin
               if (s_q.wstrb[0]) s_d.ext_sel[7:0] = s_q.wdata[7:0];
               if (s_q.wstrb[1]) s_d.ext_sel[15:8] = s_q.wdata[15:8];
            end
            OFS_PEN: begin
               if (s_q.wstrb[0]) s_d.pen[7:0] = s_q.wdata[7:0];
               if (s_q.wstrb[1]) s_d.pen[13:8] = s_q.wdata[13:8];
            end
            OFS_PEND, OFS_LEVEL: ;
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end

      // AXI read
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            OFS_PRIO0:  s_d.rdata[7:0] = s_q.prio[7:0];
            OFS_PRIO1:  s_d.rdata[7:0] = s_q.prio[15:8];
            OFS_PRIO2:  s_d.rdata[7:0] = s_q.prio[23:16];
            OFS_PRIO3:  s_d.rdata[7:0] = {PRIO3_RO, s_q.prio[27:24]};
            OFS_EXTCFG: s_d.rdata[9:0] = s_q.ext_cfg;
            OFS_EXTSEL: s_d.rdata[15:0] = s_q.ext_sel;
            OFS_PEN:    s_d.rdata[13:0] = s_q.pen;
            OFS_PEND:   s_d.rdata[14:0] = {s_q.tli_pend, s_q.pend};
            OFS_LEVEL:  s_d.rdata[7:0] = condition_code_reg;
            default:    rd_hit = 1'b0;
         endcase
         s_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end

      // Sources
      s_d.tli_q = top_level_pin_irq;
      s_d.grp_q = grp;
      s_d.pend = pend_d;
      s_d.tli_pend = s_q.tli_pend | tli_ev;
      if (halt_mode) begin
         s_d.halt_exit = 1'b1;
      end

      // Entry and return sequencing
      case (s_q.st)
         S_IDLE: begin
            if (lvl_wr) begin
               s_d.lvl = lvl_wdata;
            end
            if (instr_end) begin
               if (interrupt_return_instr_instr) begin
                  s_d.st = S_POP;
                  s_d.cnt = 3'h0;
               end else if (trap_instr) begin
                  s_d.st = S_PUSH;
                  s_d.cnt = 3'h0;
                  s_d.vec = VEC_TRAP;
                  s_d.new_lvl = LVL3;
               end else if (tli_ok) begin
                  s_d.st = S_PUSH;
                  s_d.cnt = 3'h0;
                  s_d.vec = VEC_TOP;
                  s_d.new_lvl = LVL3;
                  s_d.tli_pend = tli_ev;
                  s_d.halt_exit = 1'b0;
               end else if (win_v) begin
                  s_d.st = S_PUSH;
                  s_d.cnt = 3'h0;
                  s_d.vec = VEC_TOP - {11'h000, win_i, 1'b0};
                  s_d.new_lvl = s_q.prio[2*win_i+:2];
                  s_d.halt_exit = 1'b0;
               end
            end
         end
         S_PUSH: begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == STK_LAST) begin
               s_d.st = S_FETCH;
               s_d.lvl = s_q.new_lvl;
            end
         end
         S_FETCH: begin
            s_d.st = S_IDLE;
         end
         S_POP: begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h0) begin
               s_d.lvl = {pop_data[CC_I1_BIT], pop_data[CC_I0_BIT]};
            end
            if (s_q.cnt == STK_LAST) begin
               s_d.st = S_IDLE;
            end
         end
         default: s_d.st = S_IDLE;
      endcase

      // Reset starts the boot vector at level three, no stacking
      if (!aresetn) begin
         s_d = '0;
         s_d.prio = {PRIO3_RO, PRIO_RST[3:0], PRIO_RST, PRIO_RST, PRIO_RST};
         s_d.lvl = LVL3;
         s_d.st = S_FETCH;
         s_d.vec = VEC_RST;
         s_d.tli_q = top_level_pin_irq;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_awready = ~s_q.aw_v;
   assign s_axi_wready  = ~s_q.w_v;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = ~s_q.rvalid;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;

   // Push order PCL, PCH, X, A, CC; pop order CC, A, X, PCH, PCL
   assign busy        = s_q.st != S_IDLE;
   assign stack_push  = s_q.st == S_PUSH;
   assign stack_pop   = s_q.st == S_POP;
   assign stack_sel   = s_q.cnt;
   assign fetch       = s_q.st == S_FETCH;
   assign vector_addr = s_q.vec;

   // Level bits only; stack depth is not checked
   always_comb begin
      condition_code_reg = 8'h00;
      condition_code_reg[CC_I1_BIT] = s_q.lvl[1];
      condition_code_reg[CC_I0_BIT] = s_q.lvl[0];
   end

   // Wake from halt or wait
   assign wake = (halt_mode & (|(s_q.pend & HALT_WAKE) | s_q.tli_pend)) |
                 (wait_mode & (|s_q.pend | s_q.tli_pend));

endmodule

// ==== dv/nic_core_model.sv ====
// Core stack model that feeds back pushed condition codes
`timescale 1ns/100ps
module nic_core_model (
   // Clock
   input  wire logic       aclk,
   // Stack traffic
   input  wire logic       stack_push,
   input  wire logic       stack_pop,
   input  wire logic [2:0] stack_sel,
   input  wire logic [7:0] condition_code_reg,
   output logic [7:0]      pop_data
);
   logic [7:0] stk_q [8];
   logic [2:0] sp_q   = 3'h0;
   logic [7:0] junk_q = 8'hA5;
   // Only the condition code byte is meaningful, else a toggling pattern
   assign pop_data = (stack_pop && stack_sel == 3'h0) ? stk_q[sp_q - 3'h1] : junk_q;
   always @(posedge aclk) begin
      junk_q <= ~junk_q;
      if (stack_push && stack_sel == 3'h4) begin
         stk_q[sp_q] <= condition_code_reg;
         sp_q <= sp_q + 3'h1;
      end
      if (stack_pop && stack_sel == 3'h0) begin
         sp_q <= sp_q - 3'h1;
      end
   end
endmodule

// ==== dv/nic_top_chk.sv ====
// Port assertions of the interrupt controller
`timescale 1ns/100ps
module nic_top_chk
   import nic_pkg::*;
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Core side
   input wire logic        instr_end,
   input wire logic        trap_instr,
   input wire logic        interrupt_return_instr_instr,
   input wire logic        lvl_wr,
   input wire logic [1:0]  lvl_wdata,
   input wire logic [7:0]  pop_data,
   input wire logic        busy,
   input wire logic        stack_push,
   input wire logic        stack_pop,
   input wire logic [2:0]  stack_sel,
   input wire logic        fetch,
   input wire logic [15:0] vector_addr,
   input wire logic [7:0]  condition_code_reg
);
   logic [7:0] cap_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Popped condition code capture
   always_ff @(posedge aclk) begin
      if (stack_pop && stack_sel == 3'h0) begin
         cap_q <= pop_data & 8'h28;
      end
   end
   a_trap_entry: assert property (!busy && instr_end && trap_instr && !interrupt_return_instr_instr |=>
      stack_push [*5] ##1 fetch && vector_addr == VEC_TRAP && condition_code_reg == 8'h28)
      else $error("trap entry sequence wrong");
   a_push_order: assert property ($rose(stack_push) |-> stack_sel == 3'h0 ##1 stack_sel == 3'h1
      ##3 stack_sel == 3'h4 ##1 !stack_push && fetch) else $error("push order wrong");
   a_pop_len: assert property ($rose(stack_pop) |-> stack_pop [*5] ##1 !stack_pop)
      else $error("pop length wrong");
   a_pop_level: assert property ($fell(stack_pop) |-> condition_code_reg == cap_q)
      else $error("level not restored");
   a_cc_bits: assert property ((condition_code_reg & 8'hD7) == 8'h00)
      else $error("stray condition code bits");
   a_reset_entry: assert property ($rose(aresetn) |-> fetch && vector_addr == VEC_RST
      && condition_code_reg == 8'h28) else $error("reset entry wrong");
   a_lvl_write: assert property (!busy && lvl_wr && !instr_end |=>
      {condition_code_reg[5], condition_code_reg[3]} == $past(lvl_wdata)) else $error("level write lost");
   a_top_level3: assert property (fetch && vector_addr == VEC_TOP |-> condition_code_reg == 8'h28)
      else $error("top pin level wrong");
   a_vec_slot: assert property (fetch |-> vector_addr >= 16'hFFE0 && !vector_addr[0] ##1 !fetch && !busy)
      else $error("vector slot wrong");
   c_trap: cover property (fetch && vector_addr == VEC_TRAP);
   c_top: cover property (fetch && vector_addr == VEC_TOP);
   c_pop: cover property ($fell(stack_pop));
endmodule
bind nic_top nic_top_chk i_nic_top_chk (.aclk, .aresetn, .instr_end, .trap_instr, .interrupt_return_instr_instr, .lvl_wr,
   .lvl_wdata, .pop_data, .busy, .stack_push, .stack_pop, .stack_sel, .fetch, .vector_addr, .condition_code_reg);

// ==== dv/tb_nested_interrupt_controller.sv ====
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_nested_interrupt_controller
   import nic_pkg::*;
;
   logic        aclk = 1'h0, aresetn = 1'h0, instr_end = 1'h0, trap_instr = 1'h0, interrupt_return_instr_instr = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, lvl_wr = 1'h0;
   logic        top_level_pin_irq = 1'h0, halt_mode = 1'h0, wait_mode = 1'h0;
   logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  lvl_wdata = 2'h0, s_axi_bresp, s_axi_rresp;
   logic [15:0] ext_pin = 16'h0, vector_addr;
   logic [13:0] periph_flag = 14'h0, periph_clr = 14'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        busy, stack_push, stack_pop, fetch, wake;
   logic [2:0]  stack_sel;
   logic [7:0]  condition_code_reg, pop_data;
   logic [1:0]  lvls [4] = '{LVL1, LVL2, LVL3, LVL0};
   int          err_count = 0, check_count = 0, cyc_n = 0;
   nic_top i_nic_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .top_level_pin_irq, .ext_pin, .periph_flag, .periph_clr, .instr_end, .trap_instr, .interrupt_return_instr_instr, .lvl_wr,
      .lvl_wdata, .halt_mode, .wait_mode, .pop_data, .busy, .stack_push, .stack_pop, .stack_sel, .fetch,
      .vector_addr, .condition_code_reg, .wake);
   nic_core_model i_nic_core_model (.aclk, .stack_push, .stack_pop, .stack_sel, .condition_code_reg, .pop_data);
   ////////////////////////////////////////
   always #10 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         err_count++;
         close_out();
      end
   end
   task automatic close_out();
      if (err_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      `CHK(s_axi_bresp, r)
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, r)
   endtask
   // One instruction end, then compare fetched vector and level
   task automatic go(input logic t, input logic i, input logic [15:0] v, input logic [7:0] c);
      logic [15:0] got = 16'h0;
      @(posedge aclk);
      instr_end <= 1'h1;
      trap_instr <= t;
      interrupt_return_instr_instr <= i;
      @(posedge aclk);
      instr_end <= 1'h0;
      trap_instr <= 1'h0;
      interrupt_return_instr_instr <= 1'h0;
      repeat (8) begin
         @(posedge aclk);
         if (fetch) got = vector_addr;
      end
      `CHK(got, v)
      `CHK(condition_code_reg, c)
   endtask
   task automatic lv(input logic [1:0] l);
      @(posedge aclk);
      lvl_wr <= 1'h1;
      lvl_wdata <= l;
      @(posedge aclk);
      lvl_wr <= 1'h0;
      @(posedge aclk);
   endtask
   ////////////////////////////////////////
   initial begin
      cyc(8);
      aresetn <= 1'h1;
      cyc(3);
      `CHK(condition_code_reg, 8'h28)
      rd(OFS_PRIO0, 32'hFF, RESP_OKAY);
      wr(OFS_PRIO3, 32'h0, RESP_OKAY);
      rd(OFS_PRIO3, 32'hF0, RESP_OKAY);
      wr(6'h24, 32'h0, RESP_SLVERR);
      rd(6'h24, 32'h0, RESP_SLVERR);
      wr(OFS_PRIO1, 32'hCF, RESP_OKAY);
      wr(OFS_PRIO1, 32'h64, RESP_OKAY);
      rd(OFS_PRIO1, 32'h44, RESP_OKAY);
      foreach (lvls[k]) begin
         lv(lvls[k]);
         `CHK(condition_code_reg, {2'h0, lvls[k][1], 1'h0, lvls[k][0], 3'h0})
      end
      // Vector 1 at level 2, vector 7 at level 1
      wr(OFS_PRIO0, 32'hF3, RESP_OKAY);
      wr(OFS_PRIO1, 32'h7F, RESP_OKAY);
      periph_flag <= 14'h0082;
      go(1'h0, 1'h0, 16'h0, 8'h20);
      wr(OFS_PEN, 32'h82, RESP_OKAY);
      go(1'h0, 1'h0, 16'hFFF8, 8'h00);
      go(1'h0, 1'h0, 16'h0, 8'h00);
      periph_flag <= 14'h0080;
      periph_clr <= 14'h0002;
      cyc(1);
      periph_clr <= 14'h0;
      go(1'h0, 1'h1, 16'h0, 8'h20);
      go(1'h0, 1'h0, 16'hFFEC, 8'h08);
      periph_flag <= 14'h0;
      periph_clr <= 14'h0080;
      cyc(1);
      periph_clr <= 14'h0;
      go(1'h0, 1'h1, 16'h0, 8'h20);
      // Pending request dropped by its clear access
      wr(OFS_PEN, 32'h40, RESP_OKAY);
      lv(LVL3);
      periph_flag <= 14'h0040;
      cyc(1);
      periph_flag <= 14'h0;
      go(1'h0, 1'h0, 16'h0, 8'h28);
      periph_clr <= 14'h0040;
      cyc(1);
      periph_clr <= 14'h0;
      lv(LVL0);
      go(1'h0, 1'h0, 16'h0, 8'h20);
      // Trap, then top pin inside the trap handler
      wr(OFS_EXTCFG, 32'h05, RESP_OKAY);
      go(1'h1, 1'h0, VEC_TRAP, 8'h28);
      top_level_pin_irq <= 1'h1;
      go(1'h0, 1'h0, VEC_TOP, 8'h28);
      top_level_pin_irq <= 1'h0;
      go(1'h0, 1'h1, 16'h0, 8'h28);
      go(1'h0, 1'h1, 16'h0, 8'h20);
      // Group 0 pins 1 and 2 selected, rising edge
      wr(OFS_EXTSEL, 32'h06, RESP_OKAY);
      wr(OFS_PRIO0, 32'hD3, RESP_OKAY);
      ext_pin <= 16'h0008;
      go(1'h0, 1'h0, 16'h0, 8'h20);
      ext_pin <= 16'h000C;
      cyc(1);
      ext_pin <= 16'h0;
      go(1'h0, 1'h0, 16'hFFF6, 8'h08);
      go(1'h0, 1'h1, 16'h0, 8'h20);
      go(1'h0, 1'h0, 16'h0, 8'h20);
      // Wake from wait and halt
      wr(OFS_PEN, 32'h100, RESP_OKAY);
      periph_flag <= 14'h0100;
      halt_mode <= 1'h1;
      cyc(2);
      `CHK(wake, 1'h0)
      halt_mode <= 1'h0;
      wait_mode <= 1'h1;
      cyc(2);
      `CHK(wake, 1'h1)
      wait_mode <= 1'h0;
      halt_mode <= 1'h1;
      top_level_pin_irq <= 1'h1;
      cyc(2);
      `CHK(wake, 1'h1)
      halt_mode <= 1'h0;
      top_level_pin_irq <= 1'h0;
      go(1'h0, 1'h0, VEC_TOP, 8'h28);
      go(1'h0, 1'h1, 16'h0, 8'h20);
      // Halt exit: wake-capable vector 7 first, level-3 vector 8 right after
      wr(OFS_PEN, 32'h180, RESP_OKAY);
      periph_flag <= 14'h0180;
      halt_mode <= 1'h1;
      cyc(1);
      halt_mode <= 1'h0;
      go(1'h0, 1'h0, 16'hFFEC, 8'h08);
      go(1'h0, 1'h0, 16'hFFEA, 8'h28);
      close_out();
   end
endmodule
